// ---- logic/inertial_output_registers.sv ----
// Read-only output word set of the inertial module, read over a 16-bit serial link.
// Assumes sample data arrives on the system clock; the link pins are asynchronous.
//
// How it works
// - X rate low word at 0x04, high word at 0x06, both read-only.
// - Y rate low word at 0x08, high word at 0x0A, both read-only.
// - Z rate low word at 0x0C, high word at 0x0E, both read-only.
// - Rate high word is twos complement, zero rate reads 0x0000.
// - Rate low word extends resolution below the high word's LSB.
// - Accel high word over low word forms one 32-bit twos complement value.
// - Accel axes match the rate axes and include static gravity.
// - Accel high word spans plus or minus 40 g, 1.25 mg per count.
// - 16-bit accel full scale reads 0x7D00 and 0x8300.
// - 32-bit accel full scale reads 0x7D000000 and 0x83000000.
// - X accel low word at 0x10, high word at 0x12, read-only.
// - Y accel low word at 0x14, read-only.
// - Rate count weight depends on the model's range variant.
`timescale 1ns/10ps
`default_nettype none

module inertial_output_registers
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic sampleValid,
   input wire inertial_regs_pkg::sample_s sample,
   input wire inertial_regs_pkg::link_in_s linkIn,
   output var inertial_regs_pkg::link_out_s linkOut
);
   import inertial_regs_pkg::*;

   state_s s_reg;
   state_s s_next;
   logic sclkRise;
   logic sclkFall;
   logic csActive;
   logic [15:0] frameWord;
   logic [AXES-1:0][31:0] clamped;
   logic [WORD_BITS-1:0] loadWord [WORD_COUNT];

   // Signed saturation to a full-scale span
   function automatic logic [31:0] clampValue(
      input logic [31:0] value,
      input logic [31:0] hi,
      input logic [31:0] lo
   );
      if ($signed(value) > $signed(hi))
         return hi;
      else if ($signed(value) < $signed(lo))
         return lo;
      else
         return value;
   endfunction

   // Word lookup by byte address; odd addresses give the same word
   function automatic logic [15:0] readWord(
      input logic [6:0] addr,
      input logic [WORD_COUNT-1:0][WORD_BITS-1:0] words
   );
      logic [6:0] offset;
      offset = 7'(addr - ADDR_FIRST);
      if (addr >= ADDR_FIRST && addr <= ADDR_LAST)
         return words[offset[4:1]];
      else
         return ZERO_WORD;
   endfunction

   assign sclkRise = s_reg.sclkSync[1] & ~s_reg.sclkPrev;
   assign sclkFall = ~s_reg.sclkSync[1] & s_reg.sclkPrev;
   assign csActive = ~s_reg.csSync[1];
   assign frameWord = {s_reg.shiftIn[14:0], s_reg.mosiSync[1]};

   // even index low half, odd index high half
   for (genvar w = 0; w < WORD_COUNT; w++)
   begin : gWord
      assign loadWord[w] = clamped[w / 2][WORD_BITS * (w % 2) +: WORD_BITS];
   end

   always_comb
   begin
      // rate counts kept within the signed full-scale span
      for (int a = 0; a < RATE_AXES; a++)
      begin
         clamped[a] = clampValue(sample.rate[a], RATE_FULL_POS, RATE_FULL_NEG);
      end
      // accel limited to 0x7D00/0x8300 in the high word
      // same limits on the combined value
      for (int a = 0; a < ACCEL_AXES; a++)
      begin
         clamped[RATE_AXES + a] = clampValue(sample.accel[a], ACCEL_FULL_POS, ACCEL_FULL_NEG);
      end
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.sclkSync = {s_reg.sclkSync[0], linkIn.sclk};
      s_next.csSync = {s_reg.csSync[0], linkIn.csN};
      s_next.mosiSync = {s_reg.mosiSync[0], linkIn.mosi};
      s_next.sclkPrev = s_reg.sclkSync[1];

      // all words load from one sample in one cycle
      // even index low half, odd index high half of a 32-bit value
      // low word carries bits [15:0] below the high word
      // accel words fed from the same sample as the rate words
      // accel high word passes 1.25 mg counts unchanged
      // rate counts pass as delivered at the model's scale
      if (sampleValid)
      begin
         for (int i = 0; i < WORD_COUNT; i++)
         begin
            s_next.words[i] = loadWord[i];
         end
      end

      unique case (s_reg.link)
         LINK_IDLE:
         begin
            s_next.misoOe = 1'b0;
            s_next.bitCnt = 4'h0;
            if (csActive)
            begin
               s_next.link = LINK_SHIFT;
               s_next.misoOe = 1'b1;
            end
         end
         LINK_SHIFT:
         begin
            if (!csActive)
            begin
               // Cut frame dropped; unsent answer bits follow next frame
               s_next.link = LINK_IDLE;
               s_next.misoOe = 1'b0;
               s_next.bitCnt = 4'h0;
            end
            else
            begin
               if (sclkFall)
               begin
                  s_next.misoBit = s_reg.shiftOut[15];
                  s_next.shiftOut = {s_reg.shiftOut[14:0], 1'b0};
               end
               if (sclkRise)
               begin
                  s_next.shiftIn = frameWord;
                  s_next.bitCnt = 4'(s_reg.bitCnt + 4'h1);
                  if (s_reg.bitCnt == 4'(FRAME_BITS - 1))
                  begin
                     s_next.bitCnt = 4'h0;
                     // words answer in the next frame
                     // accel x words in the same map
                     // accel y low word in the same map
                     if (!frameWord[CMD_WRITE_BIT])
                        s_next.shiftOut = readWord(frameWord[CMD_ADDR_MSB:CMD_ADDR_LSB],
                           s_reg.words);
                     else
                        s_next.shiftOut = ZERO_WORD;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         s_reg.link <= LINK_IDLE;
         s_reg.sclkSync <= 2'h3;
         s_reg.csSync <= 2'h3;
         s_reg.mosiSync <= 2'h0;
         s_reg.sclkPrev <= 1'b1;
         s_reg.bitCnt <= 4'h0;
         s_reg.shiftIn <= ZERO_WORD;
         s_reg.shiftOut <= ZERO_WORD;
         s_reg.misoBit <= 1'b0;
         s_reg.misoOe <= 1'b0;
         s_reg.words <= WORDS_RESET;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign linkOut = '{miso: s_reg.misoBit, misoOe: s_reg.misoOe};

endmodule

`default_nettype wire

// ---- logic/inertial_regs_pkg.sv ----
// Constants and types for the inertial output register block.
// Assumes a single 125 MHz system clock and a host that reads over a serial link.
package inertial_regs_pkg;

   // Byte addresses of the output words
   localparam logic [6:0] ADDR_RATE_X_LOW = 7'h04;
   localparam logic [6:0] ADDR_RATE_X_HIGH = 7'h06;
   localparam logic [6:0] ADDR_RATE_Y_LOW = 7'h08;
   localparam logic [6:0] ADDR_RATE_Y_HIGH = 7'h0A;
   localparam logic [6:0] ADDR_RATE_Z_LOW = 7'h0C;
   localparam logic [6:0] ADDR_RATE_Z_HIGH = 7'h0E;
   localparam logic [6:0] ADDR_ACCEL_X_LOW = 7'h10;
   localparam logic [6:0] ADDR_ACCEL_X_HIGH = 7'h12;
   localparam logic [6:0] ADDR_ACCEL_Y_LOW = 7'h14;
   localparam logic [6:0] ADDR_FIRST = ADDR_RATE_X_LOW;
   localparam logic [6:0] ADDR_LAST = 7'h15;

   localparam int WORD_COUNT = 9;
   localparam int WORD_BITS = 16;
   localparam int RATE_AXES = 3;
   localparam int ACCEL_AXES = 2;
   localparam int AXES = RATE_AXES + ACCEL_AXES;

   // Serial frame layout
   localparam int FRAME_BITS = 16;
   localparam int CMD_WRITE_BIT = 15;
   localparam int CMD_ADDR_MSB = 14;
   localparam int CMD_ADDR_LSB = 8;

   localparam logic [15:0] ZERO_WORD = 16'h0000;
   localparam logic [WORD_COUNT*WORD_BITS-1:0] WORDS_RESET = '0;

   // Full scale of the 32-bit formats
   localparam logic [31:0] RATE_FULL_POS = 32'h4E200000;
   localparam logic [31:0] RATE_FULL_NEG = 32'hB1E00000;
   localparam logic [31:0] ACCEL_FULL_POS = 32'h7D000000;
   localparam logic [31:0] ACCEL_FULL_NEG = 32'h83000000;

   // Weights of one high-word count, and the accel range in g
   localparam real RATE_SCALE_125_DPS = 0.00625;
   localparam real RATE_SCALE_500_DPS = 0.025;
   localparam real RATE_SCALE_2000_DPS = 0.1;
   localparam real ACCEL_SCALE_MG = 1.25;
   localparam real ACCEL_RANGE_G = 40.0;

   typedef enum logic [0:0] {
      LINK_IDLE = 1'b0,
      LINK_SHIFT = 1'b1
   } link_e;

   // One sample of all axes, 32-bit twos complement each
   typedef struct packed {
      logic [ACCEL_AXES-1:0][31:0] accel;
      logic [RATE_AXES-1:0][31:0] rate;
   } sample_s;

   typedef struct packed {
      logic csN;
      logic sclk;
      logic mosi;
   } link_in_s;

   typedef struct packed {
      logic miso;
      logic misoOe;
   } link_out_s;

   typedef struct packed {
      link_e link;
      logic [1:0] sclkSync;
      logic [1:0] csSync;
      logic [1:0] mosiSync;
      logic sclkPrev;
      logic [3:0] bitCnt;
      logic [15:0] shiftIn;
      logic [15:0] shiftOut;
      logic misoBit;
      logic misoOe;
      logic [WORD_COUNT-1:0][WORD_BITS-1:0] words;
   } state_s;

endpackage

// ---- test/inertial_output_registers_chk.sv ----
// Link timing checks on the ports of the output word block.
// Assumes the host keeps sclk high outside frames.
`timescale 1ns/10ps
`default_nettype none
module inertial_output_registers_chk
(
   input wire logic clock,
   input wire logic rst_n,
   input wire inertial_regs_pkg::link_in_s linkIn,
   input wire inertial_regs_pkg::link_out_s linkOut
);
   import inertial_regs_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   a_oe_off: assert property (linkIn.csN [*5] |-> !linkOut.misoOe)
      else $error("miso enable on while deselected");
   a_oe_on: assert property ((!linkIn.csN) [*5] |-> linkOut.misoOe)
      else $error("miso enable off in frame");
   a_oe_start: assert property ($fell(linkIn.csN) |-> !linkOut.misoOe ##[1:4] linkOut.misoOe)
      else $error("miso enable late");
   a_oe_rise: assert property ($rose(linkOut.misoOe) |-> !$past(linkIn.csN, 2))
      else $error("miso enable without select");
   a_oe_fall: assert property ($fell(linkOut.misoOe) |-> $past(linkIn.csN, 2))
      else $error("miso enable dropped early");
   a_oe_hold: assert property (linkOut.misoOe && !linkIn.csN |=> linkOut.misoOe)
      else $error("miso enable glitch");
   a_miso_hold: assert property (linkIn.sclk [*6] |-> $stable(linkOut.miso))
      else $error("miso moved with sclk high");
   a_miso_edge: assert property ($changed(linkOut.miso) |-> !$past(linkIn.sclk, 2))
      else $error("miso moved off a falling edge");
endmodule
`default_nettype wire

// ---- test/host_link_model.sv ----
// Host side of the serial link: mode 3 frames of up to 16 bits.
// Assumes the device holds miso from a register; timing is free of the system clock.
`timescale 1ns/10ps
`default_nettype none
module host_link_model
(
   output var inertial_regs_pkg::link_in_s linkIn,
   input wire inertial_regs_pkg::link_out_s linkOut
);
   import inertial_regs_pkg::*;
   initial linkIn = '{csN: 1'b1, sclk: 1'b1, mosi: 1'b0};
   // Shift on the fall, take miso on the rise; short n aborts the frame
   task automatic xfer(input logic [15:0] cmd, input int n, output logic [15:0] resp);
      resp = 16'h0000;
      // Non-blocking so a pin change on a clock edge never races the sync flops
      linkIn.csN <= 1'b0;
      #62.5;
      for (int i = 15; i > 15 - n; i--)
      begin
         linkIn.sclk <= 1'b0;
         linkIn.mosi <= cmd[i];
         #62.5;
         linkIn.sclk <= 1'b1;
         resp[i] = linkOut.misoOe ? linkOut.miso : ~linkOut.miso;
         #62.5;
      end
      linkIn.csN <= 1'b1;
      // Idle data line must not look like the last bit
      linkIn.mosi <= ~linkIn.mosi;
      #250;
   endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Bench for the output word block: loads samples, reads every word back.
// Assumes the host model in host_link_model.sv and the checker beside it.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import inertial_regs_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sampleValid = 1'b0;
   sample_s sample = '0;
   link_in_s linkIn;
   link_out_s linkOut;
   logic [15:0] words [10] = '{default: 16'h0000};
   logic [15:0] expNext = 16'h0000;
   logic [6:0] addrs [12] = '{7'h06, 7'h08, 7'h0A, 7'h0C, 7'h0E, 7'h10, 7'h12, 7'h14,
      7'h15, 7'h07, 7'h02, 7'h7F};
   int fail_count = 0;
   int total_checks = 0;
   initial forever #4 clock = ~clock;
   inertial_output_registers inertial_output_registers_i (.clock(clock), .rst_n(rst_n),
      .sampleValid(sampleValid), .sample(sample), .linkIn(linkIn), .linkOut(linkOut));
   host_link_model host_link_model_i (.linkIn(linkIn), .linkOut(linkOut));
   function automatic logic [31:0] limit(logic [31:0] v, logic [31:0] hi, logic [31:0] lo);
      return ($signed(v) > $signed(hi)) ? hi : (($signed(v) < $signed(lo)) ? lo : v);
   endfunction
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] want);
      total_checks++;
      if (got !== want)
      begin
         fail_count++;
         $display("wrong value read word expected %h seen %h", want, got);
      end
   endtask
   task automatic load(input logic [4:0][31:0] v);
      logic [31:0] lim;
      @(posedge clock);
      sampleValid <= 1'b1;
      sample <= v;
      @(posedge clock);
      sampleValid <= 1'b0;
      for (int k = 0; k < 5; k++)
      begin
         lim = (k < 3) ? limit(v[k], RATE_FULL_POS, RATE_FULL_NEG)
            : limit(v[k], ACCEL_FULL_POS, ACCEL_FULL_NEG);
         words[2*k] = lim[15:0];
         words[2*k+1] = lim[31:16];
      end
   endtask
   // Answer of a command arrives in the next frame
   task automatic op(input logic w, input logic [6:0] a, input int n);
      logic [15:0] r;
      host_link_model_i.xfer({w, a, w ? 8'hA5 : 8'h00}, n, r);
      if (n == 16)
      begin
         chk(r, expNext);
         expNext = (w || a < 7'h04 || a > 7'h15) ? 16'h0000 : words[(a - 7'h04) >> 1];
      end
      else
      begin
         // A cut frame sends the top bits; the rest follows in the next frame
         chk(r, expNext & ~(16'hFFFF >> n));
         expNext = expNext << n;
      end
   endtask
   initial
   begin
      logic [4:0][31:0] v;
      void'($urandom(49));
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      for (int t = 0; t < 7; t++)
      begin
         for (int k = 0; k < 5; k++)
            v[k] = (t == 1) ? 32'h7FFFFFFF : (t == 2) ? 32'h80000000
               : (t == 3) ? 32'hFFFFFFFF : $urandom();
         if (t > 0)
            load(v);
         // Every mapped word of each axis read before the next load
         op(1'b0, 7'h04, 16);
         op(1'b0, 7'h06, 7);
         for (int i = 0; i < 12; i++)
            op(1'b0, addrs[i], 16);
         op(1'b1, 7'h04, 16);
         op(1'b0, 7'h04, 16);
         op(1'b0, 7'h00, 16);
         $display("test %0d done", t);
      end
      print_verdict();
   end
   initial
   begin
      #600000;
      fail_count++;
      print_verdict();
   end
endmodule
bind inertial_output_registers inertial_output_registers_chk chk_i (.clock(clock),
   .rst_n(rst_n), .linkIn(linkIn), .linkOut(linkOut));
`default_nettype wire
